// *** ffr_pkg.sv ***
// Package: layout, reset value and carriers of the upper fault flag register
package ffr_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BIT_POS_IN = 11;
    localparam int unsigned BIT_NEG_IN = 10;
    localparam int unsigned BIT_REF_RANGE = 9;
    localparam int unsigned BIT_REF_ABSENT = 8;
    localparam int unsigned BIT_CONV = 7;
    localparam int unsigned BIT_IGNORED = 6;
    localparam int unsigned BIT_CLK_CNT = 5;
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    // Only the bits this block owns; reserved and lower bits read zero
    localparam logic [15:0] FLAG_MASK = 16'h0fe0;
    localparam int unsigned FRAME_MULT = 8;
    localparam int unsigned CNT_W = 3;

    // Fault conditions sensed by the analog front end and converter
    typedef struct packed {
        logic pos_in;
        logic neg_in;
        logic ref_range;
        logic ref_absent;
        logic conv;
    } ffr_sense_t;

    // Serial pins, sampled as synchronous to clk
    typedef struct packed {
        logic cs_n;
        logic sclk;
    } ffr_spi_t;
endpackage

// *** ffr_frame_mon.sv ***
// Serial frame watcher: clock count and ignored-access detection
`timescale 1ns/10ps
module ffr_frame_mon #(
    parameter int unsigned CNT_W = ffr_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire ffr_pkg::ffr_spi_t spi,
    input wire logic access_ignored,
    output logic clk_cnt_evt,
    output logic ignored_evt
);
    // Counter must wrap exactly at one byte of clocks
    if ((1 << CNT_W) != ffr_pkg::FRAME_MULT) begin : g_bad_cnt_w
        $error("ffr_frame_mon: CNT_W must count modulo eight");
    end

    logic cs_n_r;
    logic sclk_r;
    logic [CNT_W-1:0] edge_cnt_r;
    logic frame_start;
    logic frame_end;
    logic sclk_rise;

    assign frame_start = cs_n_r && !spi.cs_n;
    assign frame_end = !cs_n_r && spi.cs_n;
    assign sclk_rise = !spi.cs_n && !sclk_r && spi.sclk;

    // Previous pin levels for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
        end else begin
            cs_n_r <= spi.cs_n;
            sclk_r <= spi.sclk;
        end
    end

    // Edges counted modulo eight; only the remainder matters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edge_cnt_r <= '0;
        end else if (frame_start) begin
            edge_cnt_r <= '0;
        end else if (sclk_rise) begin
            edge_cnt_r <= edge_cnt_r + 1'b1;
        end
    end

    // Event pulses registered so they are clean one-cycle strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_cnt_evt <= 1'b0;
            ignored_evt <= 1'b0;
        end else begin
            clk_cnt_evt <= frame_end && (edge_cnt_r != '0);
            ignored_evt <= frame_start && access_ignored;
        end
    end

    chk_count_error: assert property (@(posedge clk) disable iff (rst)
        frame_end && (edge_cnt_r != '0) |=> clk_cnt_evt)
        else $error("short frame not reported");
    chk_count_clean: assert property (@(posedge clk) disable iff (rst)
        clk_cnt_evt |-> $past(frame_end) && $past(edge_cnt_r) != '0)
        else $error("clock count event without odd frame");
    chk_ignore_evt: assert property (@(posedge clk) disable iff (rst)
        ignored_evt |-> $past(access_ignored) && $past(frame_start))
        else $error("ignored event without blocked access");
endmodule // ffr_frame_mon

// *** ffr_fault_flag_upper.sv ***
// Upper fault flag register with sticky write-one-to-clear flags
// Contract
// - Bit 11 sets on positive input range fault
// - Bit 10 sets on negative input range fault
// - Reference range flag sets on reference fault
// - Reference absent flag sets below threshold
// - Bit 7 sets on converter clamp/calibration/saturation
// - Ignored-access flag sets on blocked access
// - Clock count flag on non-multiple-of-eight frame
// - Flag asserts only when its enable set
// - Flag reads zero clear, one detected
// - Writing one clears a flag
`timescale 1ns/10ps
module ffr_fault_flag_upper #(
    parameter int unsigned WORD_W = ffr_pkg::WORD_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire ffr_pkg::ffr_sense_t sense,
    input wire ffr_pkg::ffr_spi_t spi,
    input wire logic access_ignored,
    input wire logic [WORD_W-1:0] fault_en,
    input wire logic flag_wr,
    input wire logic [WORD_W-1:0] flag_wdata,
    output logic [WORD_W-1:0] flag_rdata
);
    // Register layout is fixed at sixteen bits
    if (WORD_W != ffr_pkg::WORD_W) begin : g_bad_word_w
        $error("ffr_fault_flag_upper: register is sixteen bits");
    end

    logic clk_cnt_evt;
    logic ignored_evt;
    logic [WORD_W-1:0] event_vec;
    logic [WORD_W-1:0] set_vec;
    logic [WORD_W-1:0] clr_vec;
    logic [WORD_W-1:0] flag_r;
    logic [WORD_W-1:0] flag_nxt;

    ffr_frame_mon #(
        .CNT_W(ffr_pkg::CNT_W)
    ) u_frame_mon (
        .clk(clk),
        .rst(rst),
        .spi(spi),
        .access_ignored(access_ignored),
        .clk_cnt_evt(clk_cnt_evt),
        .ignored_evt(ignored_evt)
    );

    // Gather fault events at their bit positions
    always_comb begin
        event_vec = '0;
        event_vec[ffr_pkg::BIT_POS_IN] = sense.pos_in;
        event_vec[ffr_pkg::BIT_NEG_IN] = sense.neg_in;
        event_vec[ffr_pkg::BIT_REF_RANGE] = sense.ref_range;
        event_vec[ffr_pkg::BIT_REF_ABSENT] = sense.ref_absent;
        event_vec[ffr_pkg::BIT_CONV] = sense.conv;
        event_vec[ffr_pkg::BIT_IGNORED] = ignored_evt;
        event_vec[ffr_pkg::BIT_CLK_CNT] = clk_cnt_evt;
    end

    // Enable gates each event; mask keeps reserved bits at zero
    assign set_vec = event_vec & fault_en & ffr_pkg::FLAG_MASK;
    assign clr_vec = flag_wr ? flag_wdata : '0;
    // Set applied after clear so a coincident fault survives
    assign flag_nxt = (flag_r & ~clr_vec) | set_vec;

    // Sticky flag storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_r <= ffr_pkg::FLAG_RESET;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Read port shows stored flags directly
    assign flag_rdata = flag_r;

    // Each fault source lands on its own bit one cycle later
    chk_pos_set: assert property (@(posedge clk) disable iff (rst)
        sense.pos_in && fault_en[ffr_pkg::BIT_POS_IN]
        |=> flag_rdata[ffr_pkg::BIT_POS_IN])
        else $error("positive input flag not set");

    chk_neg_set: assert property (@(posedge clk) disable iff (rst)
        sense.neg_in && fault_en[ffr_pkg::BIT_NEG_IN]
        |=> flag_rdata[ffr_pkg::BIT_NEG_IN])
        else $error("negative input flag not set");

    chk_ref_set: assert property (@(posedge clk) disable iff (rst)
        sense.ref_range && fault_en[ffr_pkg::BIT_REF_RANGE]
        |=> flag_rdata[ffr_pkg::BIT_REF_RANGE])
        else $error("reference range flag not set");

    chk_absent_set: assert property (@(posedge clk) disable iff (rst)
        sense.ref_absent && fault_en[ffr_pkg::BIT_REF_ABSENT]
        |=> flag_rdata[ffr_pkg::BIT_REF_ABSENT])
        else $error("reference absent flag not set");

    chk_conv_set: assert property (@(posedge clk) disable iff (rst)
        sense.conv && fault_en[ffr_pkg::BIT_CONV]
        |=> flag_rdata[ffr_pkg::BIT_CONV])
        else $error("converter flag not set");

    chk_ignore_flag: assert property (@(posedge clk) disable iff (rst)
        ignored_evt && fault_en[ffr_pkg::BIT_IGNORED]
        |=> flag_rdata[ffr_pkg::BIT_IGNORED])
        else $error("ignored access flag not set");

    chk_count_flag: assert property (@(posedge clk) disable iff (rst)
        clk_cnt_evt && fault_en[ffr_pkg::BIT_CLK_CNT]
        |=> flag_rdata[ffr_pkg::BIT_CLK_CNT])
        else $error("clock count flag not set");

    // Frame events are single strobes, so one frame sets a flag once
    chk_count_strobe: assert property (@(posedge clk) disable iff (rst)
        clk_cnt_evt |=> !clk_cnt_evt)
        else $error("clock count event longer than one cycle");

    chk_ignore_strobe: assert property (@(posedge clk)
        disable iff (rst)
        ignored_evt |=> !ignored_evt)
        else $error("ignored event longer than one cycle");

    // Enable gating, reserved bits and reset value
    chk_enable_gate: assert property (@(posedge clk) disable iff (rst)
        (flag_rdata & ~$past(flag_rdata) & ~$past(fault_en)) == '0)
        else $error("flag rose while disabled");

    chk_reserved_zero: assert property (@(posedge clk)
        disable iff (rst)
        (flag_rdata & ~ffr_pkg::FLAG_MASK) == '0)
        else $error("reserved bit read as one");

    // Reset forces the flags clear while it is held
    chk_reset_value: assert property (@(posedge clk)
        rst |-> flag_rdata == ffr_pkg::FLAG_RESET)
        else $error("flags not clear during reset");

    // Write-one-to-clear, zero writes and set priority
    chk_w1c_clear: assert property (@(posedge clk) disable iff (rst)
        flag_wr && flag_wdata[ffr_pkg::BIT_CONV] && !set_vec[ffr_pkg::BIT_CONV]
        |=> !flag_rdata[ffr_pkg::BIT_CONV])
        else $error("write one did not clear");

    chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
        (flag_rdata & $past(flag_rdata & ~clr_vec))
        == $past(flag_rdata & ~clr_vec))
        else $error("flag dropped without clear");

    chk_zero_write: assert property (@(posedge clk) disable iff (rst)
        flag_wr && (flag_wdata == '0)
        |=> flag_rdata == ($past(flag_rdata) | $past(set_vec)))
        else $error("zero write changed a flag");

    chk_write_no_set: assert property (@(posedge clk)
        disable iff (rst)
        flag_wr |=> (flag_rdata & ~$past(flag_rdata) & ~$past(set_vec)) == '0)
        else $error("write raised a flag");

    chk_multi_clear: assert property (@(posedge clk) disable iff (rst)
        flag_wr && ((flag_wdata & set_vec) == '0)
        |=> (flag_rdata & $past(flag_wdata)) == '0)
        else $error("written ones left flags set");

    chk_set_wins: assert property (@(posedge clk) disable iff (rst)
        flag_wr && ((flag_wdata & set_vec) != '0)
        |=> (flag_rdata & $past(flag_wdata & set_vec))
        == $past(flag_wdata & set_vec))
        else $error("clear beat a coincident set");

    // Per-bit copies so every owned flag is watched on its own
    for (genvar b = 0; b < WORD_W; b++) begin : g_bit_chk
        if (ffr_pkg::FLAG_MASK[b]) begin : g_owned
            chk_bit_set: assert property (@(posedge clk)
                disable iff (rst)
                set_vec[b] |=> flag_rdata[b])
                else $error("enabled fault did not set its flag");

            chk_bit_rise: assert property (@(posedge clk)
                disable iff (rst)
                $rose(flag_rdata[b]) |-> $past(event_vec[b] && fault_en[b]))
                else $error("flag rose without an enabled fault");

            chk_bit_fall: assert property (@(posedge clk)
                disable iff (rst)
                $fell(flag_rdata[b]) |-> $past(flag_wr && flag_wdata[b]))
                else $error("flag fell without a write of one");

            chk_bit_clear: assert property (@(posedge clk)
                disable iff (rst)
                flag_wr && flag_wdata[b] && !set_vec[b] |=> !flag_rdata[b])
                else $error("write of one left its flag set");

            chk_bit_hold: assert property (@(posedge clk)
                disable iff (rst)
                flag_rdata[b] && !(flag_wr && flag_wdata[b]) |=> flag_rdata[b])
                else $error("flag dropped while not written");

            chk_bit_masked: assert property (@(posedge clk)
                disable iff (rst)
                !fault_en[b] && !flag_rdata[b] |=> !flag_rdata[b])
                else $error("disabled flag became set");
        end
    end

    // Main scenarios reached by the bench
    cov_set_clear: cover property (@(posedge clk) disable iff (rst)
        flag_rdata[ffr_pkg::BIT_CONV] ##1 flag_wr
        ##1 !flag_rdata[ffr_pkg::BIT_CONV]);

    cov_count_err: cover property (@(posedge clk) disable iff (rst)
        flag_rdata[ffr_pkg::BIT_CLK_CNT]);

    cov_ignore_err: cover property (@(posedge clk) disable iff (rst)
        flag_rdata[ffr_pkg::BIT_IGNORED]);

    cov_collide: cover property (@(posedge clk) disable iff (rst)
        flag_wr && ((flag_wdata & set_vec) != '0));

    cov_masked_event: cover property (@(posedge clk) disable iff (rst)
        (event_vec != '0) && ((event_vec & fault_en) == '0));
endmodule // ffr_fault_flag_upper

// *** ffr_host_model.sv ***
// Host side model: frames the serial pins with a chosen rise count
`timescale 1ns/10ps
module ffr_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [4:0] rises,
    output ffr_pkg::ffr_spi_t spi,
    output logic busy
);
    int i;

    // Clock stands still at 0 outside frames; two cycles per level
    initial begin
        spi = 2'b10;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                spi.cs_n <= 1'b0;
                for (i = 0; i < rises; i++) begin
                    repeat (2) @(posedge clk);
                    spi.sclk <= 1'b1;
                    repeat (2) @(posedge clk);
                    spi.sclk <= 1'b0;
                end
                repeat (2) @(posedge clk);
                spi.cs_n <= 1'b1;
                // Idle gap keeps frames apart
                repeat (2) @(posedge clk);
                busy <= 1'b0;
            end
        end
    end
endmodule // ffr_host_model

// *** ffr_fault_flag_upper_test.sv ***
// Testbench for the upper fault flag register
`timescale 1ns/10ps
module ffr_fault_flag_upper_test;
    logic clk, rst, go, busy, access_ignored, flag_wr;
    logic [4:0] rises;
    ffr_pkg::ffr_sense_t sense;
    ffr_pkg::ffr_spi_t spi;
    logic [15:0] fault_en, flag_wdata, flag_rdata, exp;
    int bad_count = 0, num_checks = 0, cycles = 0, k, n;

    ffr_fault_flag_upper i_dut (.clk(clk), .rst(rst), .sense(sense),
        .spi(spi), .access_ignored(access_ignored), .fault_en(fault_en),
        .flag_wr(flag_wr), .flag_wdata(flag_wdata), .flag_rdata(flag_rdata));
    ffr_host_model i_host (.clk(clk), .go(go), .rises(rises), .spi(spi),
        .busy(busy));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] want);
        num_checks++;
        if (got !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    // Tasks start and end on a rising edge
    task automatic wr(input logic [15:0] d);
        flag_wr <= 1'b1;
        flag_wdata <= d;
        @(posedge clk);
        flag_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse(input logic [4:0] s);
        sense <= s;
        @(posedge clk);
        sense <= 5'h00;
        @(posedge clk);
    endtask

    task automatic frame(input logic [4:0] r);
        rises <= r;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (n = 0; n < 200 && busy === 1'b1; n++) @(posedge clk);
        chk16({15'h0000, busy}, 16'h0000);
    endtask

    task automatic t_sense();
        for (k = 0; k < 5; k++) begin
            exp = 16'h0001 << (ffr_pkg::BIT_CONV + k);
            fault_en <= ~exp;
            pulse(5'h01 << k);
            chk16(flag_rdata, 16'h0000);
            fault_en <= exp;
            pulse(5'h01 << k);
            chk16(flag_rdata, exp);
            wr(~exp);
            chk16(flag_rdata, exp);
            wr(exp);
            chk16(flag_rdata, 16'h0000);
        end
        $display("test sense done");
    endtask

    task automatic t_race();
        fault_en <= ffr_pkg::FLAG_MASK;
        sense <= 5'h10;
        flag_wr <= 1'b1;
        flag_wdata <= 16'h0800;
        @(posedge clk);
        sense <= 5'h00;
        flag_wr <= 1'b0;
        @(posedge clk);
        chk16(flag_rdata, 16'h0800);
        wr(16'hffff);
        chk16(flag_rdata, 16'h0000);
        $display("test race done");
    endtask

    task automatic t_frames();
        fault_en <= ffr_pkg::FLAG_MASK & ~16'h0020;
        frame(5'd3);
        chk16(flag_rdata, 16'h0000);
        fault_en <= ffr_pkg::FLAG_MASK;
        frame(5'd3);
        chk16(flag_rdata, 16'h0020);
        wr(16'hffff);
        frame(5'd16);
        chk16(flag_rdata, 16'h0000);
        access_ignored <= 1'b1;
        frame(5'd8);
        access_ignored <= 1'b0;
        chk16(flag_rdata, 16'h0040);
        $display("test frames done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        {rst, go, access_ignored, flag_wr} = 4'h8;
        {sense, rises, fault_en, flag_wdata} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk16(flag_rdata, ffr_pkg::FLAG_RESET);
        t_sense();
        t_race();
        t_frames();
        end_of_test();
    end
endmodule // ffr_fault_flag_upper_test
